// file: rtl/glue_pkg.sv
/*
  Shared constants for the reset, parity and NMI glue block.
  Assumes a 100 MHz system clock and a 16-bit memory data path of two byte lanes.
*/
package glue_pkg;
  // ------------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned LANES         = 2;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // reset release stretch after both reset sources clear, in ns
  localparam int unsigned RST_HOLD_NS   = 100;
  localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W     = 8;
  // bit positions of the port 61h style status byte
  localparam int unsigned ST_TIMER_CH2_STATUS_BIT = 5;
  localparam int unsigned ST_IOCHK_BIT  = 6;
  localparam int unsigned ST_PARERR_BIT = 7;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
endpackage

// file: rtl/odd_parity_lane.sv
/*
  One byte lane of odd-parity generation and checking.
  Assumes data and stored parity are stable when the check strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none
module odd_parity_lane (
  // byte and stored bit
  input  wire logic [7:0] i_byte,
  input  wire logic       i_stored_par,
  // results
  output logic            o_gen_par,
  output logic            o_mismatch
);
  // odd parity: nine bits together hold an odd count of ones
  assign o_gen_par  = ~(^i_byte);
  assign o_mismatch = (^{i_byte, i_stored_par}) == 1'b0;
endmodule
`default_nettype wire

// file: rtl/reset_parity_nmi_glue.sv
/*
  Reset distribution, memory parity, NMI, command-request line, ROM select,
  security jumper and test-mode detection for a PC-compatible core chip.
  Assumes all inputs are synchronous to i_sys_clk and that the memory
  controller drives the command-request line only while address enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A low keyboard-controller reset request resets the CPU through the CPU reset output.
// - The system reset output is active high and changes on system clock edges, and is set at once when i_rst rises.
// - The CPU reset output is active high and holds the CPU in reset while set.
// - A separate active-high reset output goes to the numeric coprocessor.
// - Memory parity is odd, one bit per lane, the first for the even byte, the second for the odd.
// - On every memory write the odd parity of each byte is driven onto its parity bit.
// - At the end of each memory read the stored parity of each byte is checked and a mismatch flagged.
// - While address enable is low the line is an input and a low level starts a PC-bus memory cycle.
// - The I/O channel check condition is visible as a bit of the port 61h status byte.
// - The NMI output goes high on a memory parity error or an I/O channel check.
// - The ROM chip select is active low and enables the BIOS ROM onto the data bus.
// - Security checking is enabled only while the jumper input is high.
// - Test mode is entered when reset switch, supply-stable and master request are all low.
// - Timer channel 2 output is accepted as a status input.
// - The reset switch input is active low and passes through a hysteresis filter.
module reset_parity_nmi_glue #(
  parameter int unsigned FILT_LEN = 4
) (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  // reset sources
  input  wire logic                          i_reset_switch_n,
  input  wire logic                          i_supply_stable_in,
  input  wire logic                          i_kbc_reset_req_n,
  input  wire logic                          i_master_n,
  // reset outputs
  output logic                               o_sys_reset,
  output logic                               o_cpu_reset_out,
  output logic                               o_fpu_reset_out,
  // memory parity
  input  wire logic [glue_pkg::DATA_W-1:0]   i_mem_data,
  input  wire logic                          i_mem_write,
  input  wire logic                          i_mem_read_end,
  input  wire logic                          i_parity_even_byte,
  input  wire logic                          i_parity_odd_byte,
  output logic                               o_parity_even_byte,
  output logic                               o_parity_odd_byte,
  output logic                               o_parity_oe_n,
  // nmi sources and status
  input  wire logic                          i_io_channel_check,
  input  wire logic                          i_timer_ch2_status,
  input  wire logic                          i_status_clr,
  input  wire logic                          i_irq_from_pic,
  output logic                               o_nmi,
  output logic [7:0]                         o_port61_status,
  output logic                               o_irq_to_cpu,
  // command request line
  input  wire logic                          i_aen,
  input  wire logic                          i_wake_req,
  input  wire logic                          i_cmd_request_n,
  output logic                               o_cmd_request_n,
  output logic                               o_cmd_request_oe_n,
  output logic                               o_pc_mem_cycle,
  // rom, security, test
  input  wire logic                          i_rom_access,
  input  wire logic                          i_security_jumper_in,
  output logic                               o_bios_rom_select_n,
  output logic                               o_security_en,
  output logic                               o_test_mode
);
  // ------------------------------------------------------------------
  // reset switch hysteresis filter and reset sequencing
  // ------------------------------------------------------------------
  logic [FILT_LEN-1:0]           filt_r, filt_nxt;
  logic                          sw_n_r, sw_n_nxt;
  logic [glue_pkg::RST_CNT_W-1:0] hold_r, hold_nxt;
  logic                          sys_rst_r, sys_rst_nxt;
  logic                          cpu_rst_r, cpu_rst_nxt;
  logic                          fpu_rst_r, fpu_rst_nxt;
  logic                          rst_src;

  always_comb begin
    filt_nxt = {filt_r[FILT_LEN-2:0], i_reset_switch_n};
    sw_n_nxt = sw_n_r;
    // switch level only flips after a full run of equal samples
    if (&filt_r) begin
      sw_n_nxt = 1'b1;
    end else if (~|filt_r) begin
      sw_n_nxt = 1'b0;
    end
    rst_src = ~i_supply_stable_in | ~sw_n_r;
    if (rst_src) begin
      hold_nxt = glue_pkg::RST_CNT_W'(glue_pkg::RST_HOLD_CYC);
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - 1'b1;
    end else begin
      hold_nxt = hold_r;
    end
    sys_rst_nxt = rst_src | (hold_r != '0);
    cpu_rst_nxt = sys_rst_nxt | ~i_kbc_reset_req_n;
    // coprocessor follows system reset only, not the warm cpu reset
    fpu_rst_nxt = sys_rst_nxt;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      filt_r    <= '0;
      sw_n_r    <= 1'b0;
      hold_r    <= glue_pkg::RST_CNT_W'(glue_pkg::RST_HOLD_CYC);
      sys_rst_r <= 1'b1;
      cpu_rst_r <= 1'b1;
      fpu_rst_r <= 1'b1;
    end else begin
      filt_r    <= filt_nxt;
      sw_n_r    <= sw_n_nxt;
      hold_r    <= hold_nxt;
      sys_rst_r <= sys_rst_nxt;
      cpu_rst_r <= cpu_rst_nxt;
      fpu_rst_r <= fpu_rst_nxt;
    end
  end

  assign o_sys_reset     = sys_rst_r;
  assign o_cpu_reset_out = cpu_rst_r;
  assign o_fpu_reset_out = fpu_rst_r;

  chk_cpu_kbc_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_kbc_reset_req_n |=> o_cpu_reset_out)
    else $error("cpu reset missed keyboard request");
  chk_sys_rst_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_supply_stable_in |=> o_sys_reset && o_fpu_reset_out && o_cpu_reset_out)
    else $error("resets not held while supply unstable");
  chk_rst_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_sys_reset) |-> $past(hold_r, 2) == 1 && $past(hold_r) == 0
      && !$past(rst_src))
    else $error("system reset released early");
  chk_fpu_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_fpu_reset_out == o_sys_reset)
    else $error("coprocessor reset diverged");

  // ------------------------------------------------------------------
  // parity lanes
  // ------------------------------------------------------------------
  logic [glue_pkg::LANES-1:0] gen_par, mism, stored_par;
  assign stored_par = {i_parity_odd_byte, i_parity_even_byte};

  genvar g;
  generate
    for (g = 0; g < glue_pkg::LANES; g++) begin : g_lane
      odd_parity_lane u_lane (
        .i_byte       (i_mem_data[g*8 +: 8]),
        .i_stored_par (stored_par[g]),
        .o_gen_par    (gen_par[g]),
        .o_mismatch   (mism[g])
      );
    end
  endgenerate

  logic [glue_pkg::LANES-1:0] par_out_r, par_out_nxt;
  logic                       par_oe_n_r, par_oe_n_nxt;
  logic                       par_err_r, par_err_nxt;
  logic                       iochk_r, iochk_nxt;
  logic                       nmi_r, nmi_nxt;
  logic [7:0]                 stat_r, stat_nxt;
  logic                       irq_r, irq_nxt;

  always_comb begin
    par_out_nxt  = i_mem_write ? gen_par : par_out_r;
    par_oe_n_nxt = ~i_mem_write;
    // set beats clear so a same-cycle error is never lost
    par_err_nxt  = (par_err_r & ~i_status_clr) | (i_mem_read_end & |mism);
    iochk_nxt    = (iochk_r & ~i_status_clr) | i_io_channel_check;
    nmi_nxt      = par_err_nxt | iochk_nxt;
    stat_nxt     = glue_pkg::STATUS_RST;
    stat_nxt[glue_pkg::ST_TIMER_CH2_STATUS_BIT] = i_timer_ch2_status;
    stat_nxt[glue_pkg::ST_IOCHK_BIT]  = iochk_nxt;
    stat_nxt[glue_pkg::ST_PARERR_BIT] = par_err_nxt;
    irq_nxt      = i_irq_from_pic;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      par_out_r  <= '0;
      par_oe_n_r <= 1'b1;
      par_err_r  <= 1'b0;
      iochk_r    <= 1'b0;
      nmi_r      <= 1'b0;
      stat_r     <= glue_pkg::STATUS_RST;
      irq_r      <= 1'b0;
    end else begin
      par_out_r  <= par_out_nxt;
      par_oe_n_r <= par_oe_n_nxt;
      par_err_r  <= par_err_nxt;
      iochk_r    <= iochk_nxt;
      nmi_r      <= nmi_nxt;
      stat_r     <= stat_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign o_parity_even_byte = par_out_r[0];
  assign o_parity_odd_byte  = par_out_r[1];
  assign o_parity_oe_n      = par_oe_n_r;
  assign o_nmi              = nmi_r;
  assign o_port61_status    = stat_r;
  assign o_irq_to_cpu       = irq_r;

  chk_par_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_mem_write |=> !o_parity_oe_n && (^{$past(i_mem_data[7:0]), o_parity_even_byte})
                    && (^{$past(i_mem_data[15:8]), o_parity_odd_byte}))
    else $error("written parity is not odd");
  chk_par_error: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_mem_read_end && !(^{i_mem_data[7:0], i_parity_even_byte}) |=> o_nmi
      && o_port61_status[glue_pkg::ST_PARERR_BIT])
    else $error("parity error not flagged");
  chk_par_err_odd: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_mem_read_end && !(^{i_mem_data[15:8], i_parity_odd_byte}) |=> o_nmi
      && o_port61_status[glue_pkg::ST_PARERR_BIT])
    else $error("odd lane parity error not flagged");
  chk_par_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_mem_write |=> o_parity_oe_n)
    else $error("parity pins driven outside a write");
  chk_nmi_iochk: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_io_channel_check |=> o_nmi && o_port61_status[glue_pkg::ST_IOCHK_BIT])
    else $error("channel check missed");

  // ------------------------------------------------------------------
  // command request line, rom select, jumper and test mode
  // ------------------------------------------------------------------
  logic cmd_out_r, cmd_out_nxt;
  logic cmd_oe_n_r, cmd_oe_n_nxt;
  logic pc_cyc_r, pc_cyc_nxt;
  logic rom_n_r, rom_n_nxt;
  logic sec_r, sec_nxt;
  logic test_r, test_nxt;

  always_comb begin
    cmd_oe_n_nxt = ~i_aen;
    cmd_out_nxt  = ~(i_aen & i_wake_req);
    // input phase only; our own drive must not read back as a request
    pc_cyc_nxt   = ~i_aen & cmd_oe_n_r & ~i_cmd_request_n;
    rom_n_nxt    = ~i_rom_access;
    sec_nxt      = i_security_jumper_in;
    test_nxt     = ~i_reset_switch_n & ~i_supply_stable_in & ~i_master_n;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_out_r  <= 1'b1;
      cmd_oe_n_r <= 1'b1;
      pc_cyc_r   <= 1'b0;
      rom_n_r    <= 1'b1;
      sec_r      <= 1'b0;
      test_r     <= 1'b0;
    end else begin
      cmd_out_r  <= cmd_out_nxt;
      cmd_oe_n_r <= cmd_oe_n_nxt;
      pc_cyc_r   <= pc_cyc_nxt;
      rom_n_r    <= rom_n_nxt;
      sec_r      <= sec_nxt;
      test_r     <= test_nxt;
    end
  end

  assign o_cmd_request_n    = cmd_out_r;
  assign o_cmd_request_oe_n = cmd_oe_n_r;
  assign o_pc_mem_cycle     = pc_cyc_r;
  assign o_bios_rom_select_n = rom_n_r;
  assign o_security_en      = sec_r;
  assign o_test_mode        = test_r;

  chk_cmd_phase: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_aen && i_wake_req |=> !o_cmd_request_oe_n && !o_cmd_request_n)
    else $error("wake not driven in output phase");
  chk_cmd_input: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_cmd_request_oe_n && !i_aen && !i_cmd_request_n |=> o_pc_mem_cycle)
    else $error("pc memory cycle not started");
  chk_cmd_refuse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_aen || !o_cmd_request_oe_n |=> !o_pc_mem_cycle)
    else $error("pc memory cycle started in output phase");
  chk_cmd_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_aen |=> o_cmd_request_oe_n)
    else $error("command line driven in input phase");
  chk_rom_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rom_access |=> !o_bios_rom_select_n)
    else $error("rom select not asserted");
  chk_rom_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_rom_access |=> o_bios_rom_select_n)
    else $error("rom select asserted without access");
  chk_sec_en: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_security_jumper_in |=> !o_security_en)
    else $error("security enabled with jumper low");
  chk_sec_on: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_security_jumper_in |=> o_security_en)
    else $error("security not enabled with jumper high");
  chk_test_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_reset_switch_n && !i_supply_stable_in && !i_master_n |=> o_test_mode)
    else $error("test mode not entered");
  chk_test_exit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_reset_switch_n || i_supply_stable_in || i_master_n |=> !o_test_mode)
    else $error("test mode without all three inputs low");
  chk_timer_stat: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ##1 o_port61_status[glue_pkg::ST_TIMER_CH2_STATUS_BIT] == $past(i_timer_ch2_status))
    else $error("timer status not passed");
endmodule
`default_nettype wire

// file: sim/mem_ctrl_model.sv
/*
  Far-side model: the memory controller on the command-request line and
  the stored parity bits of one memory word. Assumes the bench orders reads.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  // clock
  input  wire logic i_sys_clk,
  // command-request line
  input  wire logic i_aen,
  input  wire logic i_ask,
  input  wire logic i_cmd_out_n,
  input  wire logic i_cmd_oe_n,
  output logic      o_cmd_line_n,
  // parity pins
  input  wire logic i_rd_en,
  input  wire logic i_corrupt,
  input  wire logic i_par_even,
  input  wire logic i_par_odd,
  input  wire logic i_par_oe_n,
  output logic      o_par_even,
  output logic      o_par_odd
);
  logic [1:0] stored_r;
  logic [1:0] last_r;
  logic [1:0] pins;
  // stored bit per lane, even lane in bit 0
  always_ff @(posedge i_sys_clk) begin
    if (!i_par_oe_n) stored_r <= {i_par_odd, i_par_even};
    last_r <= pins;
  end
  // released pins show the inverse of the last level, so stale data never passes
  always_comb begin
    if (!i_par_oe_n) pins = {i_par_odd, i_par_even};
    else if (i_rd_en) pins = stored_r ^ {1'b0, i_corrupt};
    else pins = ~last_r;
  end
  assign o_par_even = pins[0];
  assign o_par_odd  = pins[1];
  // pull-up on the line; controller pulls low only in the input phase
  assign o_cmd_line_n = !i_cmd_oe_n ? i_cmd_out_n : !(i_ask && !i_aen);
endmodule
`default_nettype wire

// file: sim/tb.sv
/*
  Directed bench for the reset, parity and NMI glue block.
  Assumes the model answers on the parity pins and command-request line.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst, i_reset_switch_n, i_supply_stable_in, i_kbc_reset_req_n, i_master_n;
  logic [glue_pkg::DATA_W-1:0] i_mem_data;
  logic i_mem_write, i_mem_read_end, i_io_channel_check, i_timer_ch2_status, i_status_clr;
  logic i_irq_from_pic, i_aen, i_wake_req, i_rom_access, i_security_jumper_in;
  logic i_parity_even_byte, i_parity_odd_byte, i_cmd_request_n, ask, rd_en, corrupt;
  logic o_sys_reset, o_cpu_reset_out, o_fpu_reset_out, o_parity_even_byte, o_parity_odd_byte;
  logic o_parity_oe_n, o_nmi, o_irq_to_cpu, o_cmd_request_n, o_cmd_request_oe_n;
  logic o_pc_mem_cycle, o_bios_rom_select_n, o_security_en, o_test_mode;
  logic [7:0] o_port61_status;
  int num_errors, checks_done, cycles, n;
  logic [15:0] wdat [5] = '{16'h0100, 16'h0000, 16'hffff, 16'h7f80, 16'h0301};

  reset_parity_nmi_glue #(.FILT_LEN(4)) u_reset_parity_nmi_glue (.i_sys_clk, .i_rst,
    .i_reset_switch_n, .i_supply_stable_in, .i_kbc_reset_req_n, .i_master_n, .o_sys_reset,
    .o_cpu_reset_out, .o_fpu_reset_out, .i_mem_data, .i_mem_write, .i_mem_read_end,
    .i_parity_even_byte, .i_parity_odd_byte, .o_parity_even_byte, .o_parity_odd_byte,
    .o_parity_oe_n, .i_io_channel_check, .i_timer_ch2_status, .i_status_clr,
    .i_irq_from_pic, .o_nmi, .o_port61_status, .o_irq_to_cpu, .i_aen, .i_wake_req,
    .i_cmd_request_n, .o_cmd_request_n, .o_cmd_request_oe_n, .o_pc_mem_cycle,
    .i_rom_access, .i_security_jumper_in, .o_bios_rom_select_n, .o_security_en,
    .o_test_mode);
  mem_ctrl_model u_mem_ctrl_model (.i_sys_clk, .i_aen, .i_ask(ask),
    .i_cmd_out_n(o_cmd_request_n), .i_cmd_oe_n(o_cmd_request_oe_n),
    .o_cmd_line_n(i_cmd_request_n), .i_rd_en(rd_en), .i_corrupt(corrupt),
    .i_par_even(o_parity_even_byte), .i_par_odd(o_parity_odd_byte),
    .i_par_oe_n(o_parity_oe_n), .o_par_even(i_parity_even_byte),
    .o_par_odd(i_parity_odd_byte));

  always #5 i_sys_clk = ~i_sys_clk;
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // whole run needs well under 1000 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  // 0 system reset, 1 cpu reset, 2 test mode, 3 pc memory cycle
  function automatic logic pick(input int s);
    case (s)
      0: return o_sys_reset;
      1: return o_cpu_reset_out;
      2: return o_test_mode;
      default: return o_pc_mem_cycle;
    endcase
  endfunction
  task automatic wait_val(input int s, input logic v);
    for (n = 1; n < 60; n++) begin
      cyc(1);
      #1;
      if (pick(s) === v) break;
    end
    chk(pick(s), v);
  endtask
  task automatic resets_are(input logic [2:0] v);
    chk({o_sys_reset, o_cpu_reset_out, o_fpu_reset_out}, v);
  endtask
  task automatic clear_flags();
    cyc(1);
    i_status_clr <= 1'b1;
    cyc(1);
    i_status_clr <= 1'b0;
    cyc(1);
    #1;
    chk(o_nmi, 0);
    chk(o_port61_status, 8'h00);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    wait_val(0, 0);
    resets_are(3'h0);
    chk(n >= int'(glue_pkg::RST_HOLD_CYC), 1);
    i_reset_switch_n <= 1'b0;
    cyc(1);
    i_reset_switch_n <= 1'b1;
    cyc(4);
    #1;
    chk(o_sys_reset, 0);
    i_reset_switch_n <= 1'b0;
    cyc(8);
    #1;
    resets_are(3'h7);
    chk(o_test_mode, 0);
    i_reset_switch_n <= 1'b1;
    wait_val(0, 0);
    resets_are(3'h0);
    i_supply_stable_in <= 1'b0;
    cyc(3);
    #1;
    resets_are(3'h7);
    i_supply_stable_in <= 1'b1;
    wait_val(0, 0);
    resets_are(3'h0);
  endtask
  task automatic t_kbc();
    i_kbc_reset_req_n <= 1'b0;
    cyc(3);
    #1;
    resets_are(3'h2);
    i_kbc_reset_req_n <= 1'b1;
    wait_val(1, 0);
  endtask
  task automatic t_parity();
    foreach (wdat[i]) begin
      cyc(1);
      i_mem_data <= wdat[i];
      i_mem_write <= 1'b1;
      cyc(1);
      i_mem_write <= 1'b0;
      #1;
      chk(o_parity_oe_n, 0);
      chk({o_parity_odd_byte, o_parity_even_byte}, {~^wdat[i][15:8], ~^wdat[i][7:0]});
    end
    cyc(2);
    #1;
    chk(o_parity_oe_n, 1);
    for (int c = 0; c < 3; c++) begin
      cyc(1);
      rd_en <= 1'b1;
      corrupt <= (c == 1);
      // third pass: odd byte no longer matches its stored bit
      i_mem_data <= (c == 2) ? 16'h0201 : 16'h0301;
      i_mem_read_end <= 1'b1;
      cyc(1);
      i_mem_read_end <= 1'b0;
      rd_en <= 1'b0;
      cyc(1);
      #1;
      chk(o_nmi, c != 0);
      chk(o_port61_status[7], c != 0);
      clear_flags();
    end
  endtask
  task automatic t_iochk();
    i_io_channel_check <= 1'b1;
    cyc(1);
    i_io_channel_check <= 1'b0;
    cyc(2);
    #1;
    chk(o_nmi, 1);
    chk(o_port61_status, 8'h40);
    clear_flags();
  endtask
  task automatic t_cmd();
    i_aen <= 1'b1;
    i_wake_req <= 1'b1;
    cyc(2);
    #1;
    chk({o_cmd_request_oe_n, o_cmd_request_n, i_cmd_request_n}, 0);
    chk(o_pc_mem_cycle, 0);
    // our own low drive still stands in the cycle after aen falls
    i_aen <= 1'b0;
    cyc(1);
    #1;
    chk(o_pc_mem_cycle, 0);
    i_aen <= 1'b1;
    i_wake_req <= 1'b0;
    ask <= 1'b1;
    cyc(4);
    #1;
    chk(o_pc_mem_cycle, 0);
    i_aen <= 1'b0;
    wait_val(3, 1);
    ask <= 1'b0;
    cyc(3);
    #1;
    chk({o_pc_mem_cycle, o_cmd_request_oe_n}, 1);
  endtask
  task automatic t_misc();
    for (int v = 0; v < 2; v++) begin
      cyc(1);
      {i_rom_access, i_security_jumper_in, i_timer_ch2_status, i_irq_from_pic} <= {4{v[0]}};
      cyc(2);
      #1;
      chk(o_bios_rom_select_n, !v[0]);
      chk(o_security_en, v[0]);
      chk(o_port61_status, {2'b00, v[0], 5'h00});
      chk(o_irq_to_cpu, v[0]);
    end
  endtask
  task automatic t_test_mode();
    cyc(1);
    {i_reset_switch_n, i_supply_stable_in, i_master_n} <= 3'h0;
    wait_val(2, 1);
    i_master_n <= 1'b1;
    wait_val(2, 0);
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {i_rst, i_reset_switch_n, i_supply_stable_in, i_kbc_reset_req_n, i_master_n} = 5'h1f;
    {i_mem_write, i_mem_read_end, i_io_channel_check, i_timer_ch2_status} = 4'h0;
    {i_status_clr, i_irq_from_pic, i_aen, i_wake_req, i_rom_access} = 5'h00;
    {i_security_jumper_in, ask, rd_en, corrupt} = 4'h0;
    i_mem_data = 16'h0000;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    cyc(9);
    #1;
    resets_are(3'h7);
    cyc(1);
    i_rst <= 1'b0;
    t_reset();
    t_kbc();
    t_parity();
    t_iochk();
    t_cmd();
    t_misc();
    t_test_mode();
    print_verdict();
  end
endmodule
`default_nettype wire
